// ---- ebtc_pkg.sv ----
// Purpose: Shared constants for the eight-bit timer/counter block.
// Assumes: One 40 MHz clock; an instruction cycle spans four clocks.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
package ebtc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OFF_COUNT  = 8'h00; // Count register.
    localparam logic [7:0] OFF_OPTION = 8'h04; // Source, edge, prescale.
    localparam logic [7:0] OFF_IRQCTL = 8'h08; // Enable and overflow flag.
    localparam logic [7:0] OFF_STATUS = 8'h0c; // Sticky events, read-clear.
    localparam logic [7:0] OFF_MASK   = 8'h10; // Event mask.

    // ****************************************************************
    // Option and interrupt control field positions and reset values
    // ****************************************************************
    localparam int OPT_SRC_BIT    = 5;
    localparam int OPT_EDGE_BIT   = 4;
    localparam int OPT_BYPASS_BIT = 3;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam int IRQ_EN_BIT     = 5;
    localparam int IRQ_FLAG_BIT   = 2;
    localparam logic [7:0] IRQCTL_RESET = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int QUARTERS        = 4;  // Clocks per instruction cycle.
    localparam int WRITE_INHIBIT   = 2;  // Instruction cycles held off.
    localparam int STATUS_BITS     = 2;  // Overflow and count-step events.

endpackage : ebtc_pkg

// ---- ebtc_phase.sv ----
// Purpose: Quarter-phase generator for the instruction cycle.
// Assumes: Four clocks per instruction cycle.
// Notes:   Pulses are one clock wide.
`timescale 1ns/1ps
module ebtc_phase (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    output logic      q2_pulse,
    output logic      q4_pulse
);

    logic [1:0] phase_reg;
    logic [1:0] phase_next;

    // Next quarter of the instruction cycle.
    always_comb begin
        phase_next = phase_reg + 2'h1;
    end

    // Registered phase counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 2'h0;
        end else if (ce) begin
            phase_reg <= phase_next;
        end
    end

    // Second and fourth quarters give the two sample points.
    assign q2_pulse = ce && (phase_reg == 2'h1);
    assign q4_pulse = ce && (phase_reg == 2'h3);

endmodule : ebtc_phase

// ---- ebtc_prescaler.sv ----
// Purpose: Eight-bit prescaler dividing count events by 2 to 256.
// Assumes: Events arrive as single-clock pulses.
// Notes:   Not visible to software; cleared on count register writes.
`timescale 1ns/1ps
module ebtc_prescaler #(
    parameter int WIDTH = 8
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       event_in,
    input  wire logic [2:0] rate_sel,
    output logic            tick
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // Output pulses when bit rate_sel falls, so one tick per 2^(sel+1) events.
    always_comb begin
        count_next = count_reg;
        if (clear) begin
            count_next = '0;
        end else if (event_in) begin
            count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Registered prescale counter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end

    // A tick marks the selected bit falling, ratios 1:2 through 1:256.
    assign tick = !clear && event_in && count_reg[rate_sel] &&
                  (count_next[rate_sel] == 1'b0);

endmodule : ebtc_prescaler

// ---- ebtc_timer.sv ----
// Purpose: Eight-bit timer/counter with prescaler, behind an APB slave.
// Assumes: Inputs synchronous to clk; clock enable freezes all state.
// Notes:   Every output comes from a flip-flop.
//          Writes land at the edge at which pready is seen; reads are
//          gathered one edge earlier.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ebtc_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        sleep,
    input  wire logic        ext_count_input,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             overflow_irq,
    output logic             gate_out,
    output logic      [7:0]  count_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]  count_register_reg;
    logic [7:0]  count_register_next;
    logic [7:0]  option_reg;
    logic [7:0]  option_next;
    logic        overflow_irq_enable_reg;
    logic        overflow_irq_enable_next;
    logic        overflow_flag_reg;
    logic        overflow_flag_next;
    logic [ebtc_pkg::STATUS_BITS-1:0] status_reg;
    logic [ebtc_pkg::STATUS_BITS-1:0] status_next;
    logic [ebtc_pkg::STATUS_BITS-1:0] mask_reg;
    logic [ebtc_pkg::STATUS_BITS-1:0] mask_next;
    logic [1:0]  inhibit_reg;
    logic [1:0]  inhibit_next;
    logic        ext_sample_reg;
    logic        ext_sample_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        irq_reg;
    logic        irq_next;
    logic        ovf_irq_reg;
    logic        ovf_irq_next;
    logic        gate_reg;
    logic        gate_next;

    logic        q2_pulse;
    logic        q4_pulse;
    logic        run;
    logic        count_source_select;
    logic        source_edge_select;
    logic        prescaler_bypass;
    logic [2:0]  prescale_rate_select;
    logic        ext_edge;
    logic        raw_event;
    logic        pre_tick;
    logic        inc;
    logic        rollover;
    logic        access;
    logic        wr;
    logic        rd;
    logic        count_wr;
    logic        addr_ok;
    logic        commit;
    logic        wr_option;
    logic        wr_irqctl;
    logic        wr_mask;
    logic        rd_status;

    // Option fields.
    assign count_source_select  = option_reg[ebtc_pkg::OPT_SRC_BIT];
    assign source_edge_select   = option_reg[ebtc_pkg::OPT_EDGE_BIT];
    assign prescaler_bypass     = option_reg[ebtc_pkg::OPT_BYPASS_BIT];
    assign prescale_rate_select = option_reg[2:0];

    // Sleep freezes the timer alongside the clock enable.
    assign run = ce && !sleep;

    // ****************************************************************
    // Phase generator and prescaler
    // ****************************************************************
    // The phase counter stops in sleep, so the instruction cycle
    // resumes at the quarter where it stopped.
    ebtc_phase u_phase (
        .clk      (clk),
        .rst      (rst),
        .ce       (run),
        .q2_pulse (q2_pulse),
        .q4_pulse (q4_pulse)
    );

    // The prescaler keeps the plain clock enable so that a count write
    // in sleep still clears it; its events stop with the phases.
    ebtc_prescaler #(
        .WIDTH (8)
    ) u_pre (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .clear    (count_wr),
        .event_in (raw_event && !prescaler_bypass),
        .rate_sel (prescale_rate_select),
        .tick     (pre_tick)
    );

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == ebtc_pkg::OFF_COUNT)  ||
                     (a == ebtc_pkg::OFF_OPTION) ||
                     (a == ebtc_pkg::OFF_IRQCTL) ||
                     (a == ebtc_pkg::OFF_STATUS) ||
                     (a == ebtc_pkg::OFF_MASK);
    endfunction : known_addr

    // True when the bus address selects the register at offset off.
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    // The slave takes the request in the first access cycle and raises
    // pready for one cycle after it, so every access lasts two cycles.
    // Read data are gathered at the first edge, so a read of the status
    // register clears it at the edge at which its value is copied; an
    // event at that same edge still sets its bit, and nothing is lost.
    assign access   = psel && penable && !pready_reg;
    assign addr_ok  = known_addr(paddr);
    assign rd       = ce && access && !pwrite && addr_ok;

    // A write lands only at the edge at which the master sees pready,
    // so the new value and the answer meet the master at one edge.
    assign commit   = psel && penable && pready_reg;
    assign wr       = ce && commit && pwrite && addr_ok;

    // One strobe per register, decoded here once for every user.
    assign count_wr  = wr && reg_hit(paddr, ebtc_pkg::OFF_COUNT);
    assign wr_option = wr && reg_hit(paddr, ebtc_pkg::OFF_OPTION);
    assign wr_irqctl = wr && reg_hit(paddr, ebtc_pkg::OFF_IRQCTL);
    assign wr_mask   = wr && reg_hit(paddr, ebtc_pkg::OFF_MASK);
    assign rd_status = rd && reg_hit(paddr, ebtc_pkg::OFF_STATUS);

    // ****************************************************************
    // Count path
    // ****************************************************************
    // The input is sampled only at the two quarter points, so an edge
    // narrower than half an instruction cycle may be missed.
    always_comb begin
        ext_sample_next = ext_sample_reg;
        if (q2_pulse || q4_pulse) begin
            ext_sample_next = ext_count_input;
        end
    end

    // Edge seen when the sample changes towards the selected level.
    assign ext_edge = (q2_pulse || q4_pulse) &&
                      (ext_count_input != ext_sample_reg) &&
                      (ext_count_input == !source_edge_select);

    // Timer mode gives one event per instruction cycle at the fourth quarter.
    assign raw_event = count_source_select ? ext_edge
                                           : q4_pulse;
    assign inc = run && (inhibit_reg == 2'h0) &&
                 (prescaler_bypass ? raw_event
                                   : pre_tick);
    assign rollover = inc && (count_register_reg == 8'hff);

    // Count register and write inhibit updates.
    // A write, in sleep as well, reloads the hold-off, so the first
    // steps after wake-up still honour the two-cycle inhibit. Only the
    // fourth-quarter pulse ages the hold-off, and it stops in sleep.
    always_comb begin
        count_register_next = count_register_reg;
        inhibit_next        = inhibit_reg;
        if (count_wr) begin
            count_register_next = pwdata[7:0];
            inhibit_next = 2'(ebtc_pkg::WRITE_INHIBIT);
        end else begin
            if (inc) begin
                count_register_next = count_register_reg + 8'h01;
            end
            if (q4_pulse && inhibit_reg != 2'h0) begin
                inhibit_next = inhibit_reg - 2'h1;
            end
        end
    end

    // ****************************************************************
    // Registers written by software
    // ****************************************************************
    // Option, interrupt control and mask. A write of zero to the flag
    // bit clears it; a rollover in that same cycle wins, so no
    // overflow can slip past software unnoticed.
    always_comb begin
        option_next              = option_reg;
        overflow_irq_enable_next = overflow_irq_enable_reg;
        overflow_flag_next       = overflow_flag_reg;
        mask_next                = mask_reg;
        if (wr_option) begin
            option_next = pwdata[7:0];
        end
        if (wr_mask) begin
            mask_next = pwdata[ebtc_pkg::STATUS_BITS-1:0];
        end
        if (wr_irqctl) begin
            overflow_irq_enable_next = pwdata[ebtc_pkg::IRQ_EN_BIT];
            overflow_flag_next = pwdata[ebtc_pkg::IRQ_FLAG_BIT];
        end
        // Hardware set wins over a software clear in the same cycle.
        if (rollover) begin
            overflow_flag_next = 1'b1;
        end
    end

    // Sticky status: bit 0 overflow, bit 1 count step; read clears.
    always_comb begin
        status_next = status_reg;
        if (rd_status) begin
            status_next = '0;
        end
        if (rollover) begin
            status_next[0] = 1'b1;
        end
        if (inc) begin
            status_next[1] = 1'b1;
        end
    end

    // ****************************************************************
    // Bus answer and outputs
    // ****************************************************************
    // Read data stand in prdata until the next read, so a master may
    // take them at its pready edge or later. An unmapped address reads
    // zero and answers with pslverr; a write there changes nothing.
    always_comb begin
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = access;
        if (access && !pwrite) begin
            prdata_next = 32'h0000_0000;
            unique case (paddr)
                ebtc_pkg::OFF_COUNT:  prdata_next[7:0] = count_register_reg;
                ebtc_pkg::OFF_OPTION: prdata_next[7:0] = option_reg;
                ebtc_pkg::OFF_IRQCTL: begin
                    prdata_next[ebtc_pkg::IRQ_EN_BIT] =
                        overflow_irq_enable_reg;
                    prdata_next[ebtc_pkg::IRQ_FLAG_BIT] = overflow_flag_reg;
                end
                ebtc_pkg::OFF_STATUS:
                    prdata_next[ebtc_pkg::STATUS_BITS-1:0] = status_reg;
                ebtc_pkg::OFF_MASK:
                    prdata_next[ebtc_pkg::STATUS_BITS-1:0] = mask_reg;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (access && !addr_ok) begin
            pslverr_next = 1'b1; // Unmapped address.
        end
        // Request only; no wake path leaves this block during sleep.
        ovf_irq_next = overflow_flag_next &&
                       overflow_irq_enable_next;
        // The level follows the sticky status through the mask.
        irq_next  = |(status_next & mask_next);
        gate_next = rollover;
    end

    // Registered state of the whole block.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_register_reg      <= 8'h00;
            option_reg              <= ebtc_pkg::OPTION_RESET;
            overflow_irq_enable_reg <= 1'b0;
            overflow_flag_reg       <= 1'b0;
            status_reg              <= '0;
            mask_reg                <= '0;
            inhibit_reg             <= 2'h0;
            ext_sample_reg          <= 1'b0;
            prdata_reg              <= 32'h0000_0000;
            pready_reg              <= 1'b0;
            pslverr_reg             <= 1'b0;
            irq_reg                 <= 1'b0;
            ovf_irq_reg             <= 1'b0;
            gate_reg                <= 1'b0;
        end else if (ce) begin
            count_register_reg      <= count_register_next;
            inhibit_reg             <= inhibit_next;
            ext_sample_reg          <= ext_sample_next;
            option_reg              <= option_next;
            overflow_irq_enable_reg <= overflow_irq_enable_next;
            overflow_flag_reg       <= overflow_flag_next;
            status_reg              <= status_next;
            mask_reg                <= mask_next;
            prdata_reg              <= prdata_next;
            pready_reg              <= pready_next;
            pslverr_reg             <= pslverr_next;
            irq_reg                 <= irq_next;
            ovf_irq_reg             <= ovf_irq_next;
            gate_reg                <= gate_next;
        end
    end

    // Outputs come straight from the registers above.
    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign irq          = irq_reg;
    assign overflow_irq = ovf_irq_reg;
    assign gate_out     = gate_reg;
    assign count_out    = count_register_reg;

endmodule : ebtc_timer

// ---- ebtc_assertions.sv ----
// Purpose: Port-level checks for the eight-bit timer/counter.
// Assumes: Bound into ebtc_timer; one clock domain.
// Notes:   Only the top module's ports are visible here.
`timescale 1ns/1ps
module ebtc_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        sleep,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gate_out,
    input wire logic [7:0]  count_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ********
    // Sequences
    // ********
    // A count write at its answer cycle, and a rollover with no write.
    sequence cnt_wr_s;
        psel && penable && pwrite && pready && paddr == ebtc_pkg::OFF_COUNT;
    endsequence
    sequence roll_s;
        !psel && count_out == 8'hff ##1 count_out == 8'h00;
    endsequence

    // ********
    // Assertions
    // ********
    apb_answer_a: assert property (psel && penable && !pready && ce |=> pready)
        else $error("access not answered after one cycle");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 0)
        else $error("upper read bits not zero");
    write_hold_a: assert property (cnt_wr_s |-> ##2 $stable(count_out)[*6])
        else $error("count stepped inside write hold-off");
    step_one_a: assert property (
        !psel && !$past(psel) && count_out != $past(count_out)
        |-> count_out == $past(count_out) + 8'h01)
        else $error("count moved by other than one");
    roll_gate_a: assert property (roll_s |-> ##[0:1] gate_out)
        else $error("no gate pulse at rollover");
    gate_pulse_a: assert property (gate_out |=> !gate_out)
        else $error("gate pulse longer than one cycle");
    sleep_hold_a: assert property (
        (sleep && !psel)[*4] |-> $stable(count_out))
        else $error("count moved during sleep");
    sleep_wake_a: assert property ((sleep && !psel)[*3] |-> !gate_out)
        else $error("overflow event during sleep");
endmodule : ebtc_assertions

// ---- ebtc_ext_source.sv ----
// Purpose: Model of the external clock source on the count pin.
// Assumes: Bursts are requested by a one-cycle go pulse.
// Notes:   The pin rests low between bursts, as a gated source would.
`timescale 1ns/1ps
module ebtc_ext_source (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] pulses,
    input  wire logic [3:0] half,
    output logic            busy,
    output logic            pin
);
    // Whole pulses only; each level is held half clocks so it is sampled.
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                repeat (pulses) begin
                    pin <= 1'b1;
                    repeat (half) @(posedge clk);
                    pin <= 1'b0;
                    repeat (half) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : ebtc_ext_source

// ---- ebtc_timer_bench.sv ----
// Purpose: Self-checking bench for the eight-bit timer/counter.
// Assumes: APB answers in two cycles; four clocks per instruction cycle.
// Notes:   Counts are watched on count_out, sampled at falling edges.
`timescale 1ns/1ps
module ebtc_timer_bench;
    logic        clk, rst, ce, sleep, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, irq, overflow_irq, gate_out, e;
    logic [7:0]  count_out, pulses;
    logic [3:0]  half;
    logic        pin, go, busy;
    int          miscompares, n_checks, n;

    ebtc_timer uut (.clk(clk), .rst(rst), .ce(ce), .sleep(sleep),
        .ext_count_input(pin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .overflow_irq(overflow_irq), .gate_out(gate_out),
        .count_out(count_out));
    ebtc_ext_source src (.clk(clk), .go(go), .pulses(pulses),
        .half(half), .busy(busy), .pin(pin));

    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One APB transfer; held until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, r);
    endtask : rc

    // Waits for the count to move; n is the cycles since the call.
    task automatic step;
        logic [7:0] c;
        c = count_out;
        n = 0;
        do begin @(negedge clk); n++; end while (count_out === c);
    endtask : step

    task automatic wait_neg(input int k);
        repeat (k) @(negedge clk);
    endtask : wait_neg

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // ********
    // Clock, reset, watchdog
    // ********
    // Clock at 40 MHz.
    always #12.5 clk = ~clk;

    // The whole run needs about 4600 cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict;
    end

    // ********
    // Tests
    // ********
    // Each group below ends by printing one line.
    initial begin
        clk = 0; rst = 1; ce = 1; sleep = 0; psel = 0; penable = 0;
        pwrite = 0; paddr = 8'h00; pwdata = 32'h0; go = 0;
        pulses = 8'h05; half = 4'h8; miscompares = 0; n_checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rc("option", ebtc_pkg::OFF_OPTION, 32'hff);
        rc("irqctl", ebtc_pkg::OFF_IRQCTL, 32'h00);
        rc("count", ebtc_pkg::OFF_COUNT, 32'h00);
        rc("unmapped", 8'h14, 32'h0);
        chk("slverr", 1, e);
        $display("test reset done");
        wr(ebtc_pkg::OFF_OPTION, 32'h08);
        wr(ebtc_pkg::OFF_COUNT, 32'hfe);
        step;
        chk("count ff", 32'hff, count_out);
        step;
        chk("period", 4, n);
        chk("rollover", 0, count_out);
        wait_neg(3);
        chk("irq masked", 0, irq);
        rc("flag", ebtc_pkg::OFF_IRQCTL, 32'h04);
        chk("ovf irq off", 0, overflow_irq);
        wr(ebtc_pkg::OFF_MASK, 32'h1);
        wait_neg(3);
        chk("irq on", 1, irq);
        apb(1'b0, ebtc_pkg::OFF_STATUS, 32'h0);
        chk("status", 1, r & 32'h1);
        apb(1'b0, ebtc_pkg::OFF_STATUS, 32'h0);
        chk("status clr", 0, r & 32'h1);
        wait_neg(2);
        chk("irq off", 0, irq);
        wr(ebtc_pkg::OFF_IRQCTL, 32'h24);
        wait_neg(3);
        chk("ovf irq on", 1, overflow_irq);
        rc("flag kept", ebtc_pkg::OFF_IRQCTL, 32'h24);
        wr(ebtc_pkg::OFF_IRQCTL, 32'h20);
        wait_neg(3);
        chk("ovf irq clr", 0, overflow_irq);
        $display("test timer done");
        // Every prescale ratio, timed over one whole count period.
        for (int k = 0; k < 8; k++) begin
            wr(ebtc_pkg::OFF_OPTION, 32'(k));
            wr(ebtc_pkg::OFF_COUNT, 32'h0);
            step;
            step;
            chk("ratio", 32'(4 << (k + 1)), n);
        end
        $display("test prescaler done");
        // Rising then falling edge select on the count pin.
        for (int s = 0; s < 2; s++) begin
            wr(ebtc_pkg::OFF_OPTION, 32'h28 | 32'(s << 4));
            wr(ebtc_pkg::OFF_COUNT, 32'h0);
            repeat (12) @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wait (pin === 1'b1);
            wait_neg(5);
            chk("first edge", 32'(s == 0), count_out);
            do @(negedge clk); while (busy === 1'b1);
            wait_neg(6);
            chk("edges", 32'h5, count_out);
        end
        $display("test counter done");
        wr(ebtc_pkg::OFF_OPTION, 32'h08);
        @(posedge clk);
        sleep <= 1'b1;
        wait_neg(4);
        r = 32'(count_out);
        wait_neg(40);
        chk("sleep hold", r, count_out);
        wr(ebtc_pkg::OFF_COUNT, 32'h33);
        chk("sleep load", 32'h33, count_out);
        @(posedge clk);
        sleep <= 1'b0;
        step;
        chk("wake", 32'h34, count_out);
        // A low clock enable freezes the count like sleep does.
        @(posedge clk);
        ce <= 1'b0;
        wait_neg(2);
        r = 32'(count_out);
        wait_neg(20);
        chk("ce hold", r, count_out);
        @(posedge clk);
        ce <= 1'b1;
        $display("test sleep done");
        print_verdict;
    end
endmodule : ebtc_timer_bench

bind ebtc_timer ebtc_assertions chk_i (.clk(clk), .rst(rst), .ce(ce),
    .sleep(sleep), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_out(gate_out), .count_out(count_out));
